// *** rtl/ild_top.v ***
// input level detector with wishbone register access
// assumes a classic wishbone master on ref_clk; samples are synchronous
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ild_map.vh"

module ild_top #(
  parameter IN_W  = 14,
  parameter ACC_W = 32,
  parameter CNT_W = 18
) (
  input  wire            ref_clk,
  input  wire            rst_n,
  input  wire [IN_W-1:0] sample_in,
  input  wire            input_sample_enable,
  input  wire            wb_cyc_i,
  input  wire            wb_stb_i,
  input  wire            wb_we_i,
  input  wire [7:0]      wb_adr_i,
  input  wire [3:0]      wb_sel_i,
  input  wire [31:0]     wb_dat_i,
  output reg  [31:0]     wb_dat_o,
  output reg             wb_ack_o,
  output reg  [IN_W-1:0] fe_data_ff,
  output reg             fe_valid_ff,
  output reg             result_ready_ff
);

  // ****************************************
  // declarations
  // ****************************************
  reg  [31:0]      cfg_ff;
  reg  [31:0]      thresh_ff;
  reg  [ACC_W-1:0] acc_ff;
  reg  [CNT_W-1:0] cnt_ff;
  reg              run_ff;
  reg  [22:0]      hold_ff;
  reg  [31:0]      nxt_rdata;
  reg  [ACC_W-1:0] nxt_acc;
  reg  [CNT_W-1:0] nxt_cnt;
  reg              nxt_run;
  reg              end_ff;
  wire [IN_W-1:0]  fs_samp;
  wire             fs_vld;
  wire             fs_real;
  wire             bus_req;
  wire             wr_stb;
  wire             rd_stb;
  wire             start_wr;
  wire             msb_rd;
  wire [CNT_W-1:0] preload;
  wire [CNT_W-1:0] load_val;
  wire [ACC_W-1:0] mag_ext;
  wire [ACC_W-1:0] thr_ext;
  wire             take;
  wire             at_end;

  // ****************************************
  // front end
  // ****************************************
  ild_front #(
    .IN_W (IN_W)
  ) u_front (
    .ref_clk             (ref_clk),
    .rst_n               (rst_n),
    .sample_in           (sample_in),
    .input_sample_enable (input_sample_enable),
    .twos_fmt            (cfg_ff[`ILD_CFG_TWOS]),
    .interp_mode         (cfg_ff[`ILD_CFG_INTERP]),
    .samp_ff             (fs_samp),
    .samp_vld_ff         (fs_vld),
    .samp_real_ff        (fs_real)
  );

  // filter-facing stream, registered again so outputs come from flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fe_data_ff  <= {IN_W{1'b0}};
      fe_valid_ff <= 1'b0;
    end else begin
      fe_data_ff  <= fs_samp;
      fe_valid_ff <= fs_vld;
    end
  end

  // ****************************************
  // wishbone decode
  // ****************************************
  // ack is given one cycle after the request and dropped the cycle after
  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb   = bus_req & wb_we_i;
  assign rd_stb   = bus_req & ~wb_we_i;
  assign start_wr = wr_stb & (wb_adr_i == `ILD_ADDR_START);
  assign msb_rd   = rd_stb & (wb_adr_i == `ILD_ADDR_LVL2);

  // byte-lane merge, used for both writable registers
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer i;
    begin
      lane_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // bit select down to accumulator width; no sign or zero extension is done
  function [ACC_W-1:0] sext;
    input [31:0] v;
    begin
      sext = v[ACC_W-1:0];
    end
  endfunction

  // configuration and threshold registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff    <= `ILD_CFG_RESET;
      thresh_ff <= `ILD_THRESH_RESET;
    end else if (wr_stb) begin
      if (wb_adr_i == `ILD_ADDR_CFG) begin
        cfg_ff <= lane_merge(cfg_ff, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `ILD_ADDR_THRESH) begin
        thresh_ff <= lane_merge(thresh_ff, wb_dat_i, wb_sel_i);
      end
    end
  end

  // read mux; unmapped offsets read as zero and still ack
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `ILD_ADDR_CFG:    nxt_rdata = cfg_ff;
      `ILD_ADDR_THRESH: nxt_rdata = thresh_ff;
      `ILD_ADDR_STATUS: nxt_rdata = {30'h0000_0000, run_ff,
                                     result_ready_ff};
      `ILD_ADDR_LVL0:   nxt_rdata = {24'h00_0000, hold_ff[7:0]};
      `ILD_ADDR_LVL1:   nxt_rdata = {24'h00_0000, hold_ff[15:8]};
      `ILD_ADDR_LVL2:   nxt_rdata = {24'h00_0000, 1'b0,
                                     hold_ff[22:16]};
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  // bus answer flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (rd_stb) begin
        wb_dat_o <= nxt_rdata;
      end
    end
  end

  // ****************************************
  // level detector datapath
  // ****************************************
  // preload counts groups of four, so the two low bits stay zero
  assign preload = {cfg_ff[`ILD_CFG_PRE_HI:`ILD_CFG_PRE_LO], 2'b00};
  // field is samples/4 plus one, so one group of four comes off on load
  assign load_val = preload - {{(CNT_W-3){1'b0}}, 3'h4};
  // stuffed zeros are not samples: only enabled samples count
  assign take    = fs_vld & fs_real & run_ff;
  // magnitude of the accepted sample, threshold bit-selected to accumulator width
  assign mag_ext = {{(ACC_W-IN_W){1'b0}},
                    fs_samp[IN_W-1] ? (~fs_samp + 1'b1) : fs_samp};
  assign thr_ext = sext(thresh_ff);
  assign at_end  = take & (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});

  // counter, run state and accumulator next values
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_acc = acc_ff;
    if (start_wr) begin
      // restart clears the sum, unless end_ff is set in the same cycle, and never latches it
      nxt_cnt = load_val;
      nxt_run = 1'b1;
      nxt_acc = {ACC_W{1'b0}};
    end else if (take) begin
      nxt_acc = acc_ff + mag_ext + thr_ext;
      nxt_cnt = cnt_ff - 1'b1;
      if (at_end) begin
        if (cfg_ff[`ILD_CFG_FREE]) begin
          nxt_cnt = load_val;
        end else begin
          nxt_run = 1'b0;
        end
      end
    end
  end

  // end-of-count strobe drives the latch one cycle later
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= {CNT_W{1'b0}};
      run_ff <= 1'b0;
      acc_ff <= {ACC_W{1'b0}};
      end_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      end_ff <= at_end & ~start_wr;
      if (end_ff) begin
        acc_ff <= {ACC_W{1'b0}} + (take ? mag_ext + thr_ext
                                        : {ACC_W{1'b0}});
      end else begin
        acc_ff <= nxt_acc;
      end
    end
  end

  // ****************************************
  // holding register and result-ready flag
  // ****************************************
  // a new result wins over a clearing read in the same cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff         <= 23'h00_0000;
      result_ready_ff <= 1'b0;
    end else begin
      if (end_ff) begin
        hold_ff         <= acc_ff[ACC_W-1:ACC_W-23];
        result_ready_ff <= 1'b1;
      end else if (msb_rd) begin
        result_ready_ff <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/ild_map.vh ***
// register map, field positions and reset values of the level detector
// assumes a 32-bit classic wishbone slave with word-aligned registers
//
// What this block does
// - input samples may be offset binary or two's complement, set by config
// - gated mode takes one sample per clock while the input enable is high
// - interpolated mode stuffs zeros so the output runs every clock
// - each accepted sample is rectified and a signed threshold is added
// - sums accumulate in a 32-bit accumulator; rectified samples alone cannot overflow it in a period, but large thresholds can make it wrap
// - an 18-bit down-counter of accepted samples sets the period length
// - preload upper 16 bits come from config bits 29-14, lowest two are zero
// - counter runs free-repeating or counts down once and stops
// - free-running counter reloads on its last sample instead of reaching zero, and the result is captured each time
// - a write to the start register starts the counter at any time
// - one cycle after the last sample the upper 23 accumulator bits go to the holding register
// - a restart write never latches; only end of count updates the result
// - each latch sets the result-ready status bit
// - reading the result's most significant byte clears result-ready
// - the result is read as three byte-wide registers
`ifndef ILD_MAP_VH
`define ILD_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define ILD_ADDR_CFG      8'h00
`define ILD_ADDR_THRESH   8'h04
`define ILD_ADDR_START    8'h08
`define ILD_ADDR_STATUS   8'h0c
`define ILD_ADDR_LVL0     8'h10
`define ILD_ADDR_LVL1     8'h14
`define ILD_ADDR_LVL2     8'h18

// ****************************************
// configuration fields
// ****************************************
`define ILD_CFG_TWOS      0
`define ILD_CFG_INTERP    1
`define ILD_CFG_FREE      2
`define ILD_CFG_PRE_LO    14
`define ILD_CFG_PRE_HI    29
`define ILD_CFG_RESET     32'h0000_0000
`define ILD_THRESH_RESET  32'h0000_0000

// ****************************************
// status fields
// ****************************************
`define ILD_ST_READY      0
`define ILD_ST_RUN        1

`endif

// *** rtl/ild_front.v ***
// input controller: format conversion, gating and zero stuffing
// assumes samples and the input enable are synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none

module ild_front #(
  parameter IN_W = 14
) (
  input  wire            ref_clk,
  input  wire            rst_n,
  input  wire [IN_W-1:0] sample_in,
  input  wire            input_sample_enable,
  input  wire            twos_fmt,
  input  wire            interp_mode,
  output reg  [IN_W-1:0] samp_ff,
  output reg             samp_vld_ff,
  output reg             samp_real_ff
);

  wire [IN_W-1:0] tc_sample;

  // offset binary becomes two's complement by flipping the msb
  assign tc_sample = twos_fmt ? sample_in :
                     {~sample_in[IN_W-1], sample_in[IN_W-2:0]};

  // ****************************************
  // gated or zero-stuffed sample stage
  // ****************************************
  // interpolated mode keeps the stream valid every clock with zeros between
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_ff      <= {IN_W{1'b0}};
      samp_vld_ff  <= 1'b0;
      samp_real_ff <= 1'b0;
    end else if (interp_mode) begin
      samp_vld_ff  <= 1'b1;
      samp_real_ff <= input_sample_enable;
      samp_ff      <= input_sample_enable ? tc_sample : {IN_W{1'b0}};
    end else begin
      samp_vld_ff  <= input_sample_enable;
      samp_real_ff <= input_sample_enable;
      if (input_sample_enable) begin
        samp_ff <= tc_sample;
      end
    end
  end

endmodule

`default_nettype wire

// *** testbench/ild_monitor.sv ***
// checker on the level detector top ports
// assumes one ref_clk domain, reset active low
`timescale 1ns/1ps
`default_nettype none
`include "ild_map.vh"
// ****************************************
// port checker
// ****************************************
module ild_monitor #(
  parameter IN_W = 14
) (
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic [IN_W-1:0] sample_in,
  input wire logic            input_sample_enable,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  input wire logic [IN_W-1:0] fe_data_ff,
  input wire logic            fe_valid_ff,
  input wire logic            result_ready_ff
);
  localparam logic [IN_W-1:0] MSB = {1'b1, {(IN_W-1){1'b0}}};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // read answers, qualified by the held request
  wire rd_ack  = wb_ack_o & ~wb_we_i & wb_cyc_i & wb_stb_i;
  wire lvl2_rd = rd_ack & (wb_adr_i == `ILD_ADDR_LVL2);
  property p_ack; wb_cyc_i & wb_stb_i & ~wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_valid; input_sample_enable |-> ##2 fe_valid_ff; endproperty
  a_valid: assert property (p_valid) else $error("sample lost");
  property p_zero;
    !input_sample_enable |-> ##2 (!fe_valid_ff || fe_data_ff == '0);
  endproperty
  a_zero: assert property (p_zero) else $error("stuffed not zero");
  property p_conv;
    input_sample_enable |-> ##2 (fe_data_ff == $past(sample_in, 2)
      || fe_data_ff == ($past(sample_in, 2) ^ MSB));
  endproperty
  a_conv: assert property (p_conv) else $error("bad format");
  // ready may only fall in the ack cycle of a top byte read
  property p_clr;
    $fell(result_ready_ff) |-> lvl2_rd;
  endproperty
  a_clr: assert property (p_clr) else $error("ready lost");
  property p_unm; rd_ack && wb_adr_i > `ILD_ADDR_LVL2 |-> wb_dat_o == 0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped not zero");
  property p_lvl;
    rd_ack && (wb_adr_i == `ILD_ADDR_LVL0 || wb_adr_i == `ILD_ADDR_LVL1)
      |-> wb_dat_o[31:8] == 0;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level byte wide");
  property p_top; lvl2_rd |-> wb_dat_o[31:7] == 0; endproperty
  a_top: assert property (p_top) else $error("level over 23 bits");
  c_rdy: cover property ($rose(result_ready_ff));
  c_rd: cover property (lvl2_rd);
  c_stuff: cover property (!input_sample_enable ##2 fe_valid_ff);
endmodule
bind ild_top ild_monitor #(.IN_W(IN_W)) u_mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .sample_in(sample_in),
  .input_sample_enable(input_sample_enable), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fe_data_ff(fe_data_ff),
  .fe_valid_ff(fe_valid_ff), .result_ready_ff(result_ready_ff));
`default_nettype wire

// *** testbench/ild_adc_model.sv ***
// converter model feeding samples with an enable
// assumes requests from the bench on ref_clk
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// converter model
// ****************************************
module ild_adc_model #(
  parameter IN_W = 14
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic [IN_W-1:0] req_val,
  input  wire logic            req_go,
  output var  logic [IN_W-1:0] sample_out,
  output var  logic            sample_en
);
  // bus toggles off-sample, so stale data can never pass for new
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_out <= '0;
      sample_en  <= 1'b0;
    end else begin
      sample_out <= req_go ? req_val : ~sample_out;
      sample_en  <= req_go;
    end
  end
endmodule
`default_nettype wire

// *** testbench/ild_tb_top.sv ***
// bench for the level detector through its wishbone registers
// assumes the checker is bound and the model drives samples
`timescale 1ns/1ps
`default_nettype none
`include "ild_map.vh"
module ild_tb_top;
  logic        ref_clk, rst_n, cyc, stb, we, go, en, ack, fe_v, rdy;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, dout;
  logic [13:0] val, smp, fe_d;
  int          n_fail, n_tests, cnt;
  ild_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sample_in(smp),
    .input_sample_enable(en), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(dout), .wb_ack_o(ack), .fe_data_ff(fe_d),
    .fe_valid_ff(fe_v), .result_ready_ff(rdy));
  ild_adc_model u_adc (.ref_clk(ref_clk), .rst_n(rst_n), .req_val(val),
    .req_go(go), .sample_out(smp), .sample_en(en));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one classic cycle, held until ack is seen
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rdat, e);
  endtask
  task put4(input logic [13:0] a, b, c, d);
    logic [13:0] q[4];
    q = '{a, b, c, d};
    foreach (q[i]) begin
      @(posedge ref_clk); go <= 1'b1; val <= q[i];
      @(posedge ref_clk); go <= 1'b0;
    end
  endtask
  task wait_rdy;
    repeat (20) if (rdy !== 1'b1) @(posedge ref_clk);
  endtask
  // hang guard, far above the sequence length
  always @(posedge ref_clk) begin
    cnt <= cnt + 1;
    if (cnt == 3000) begin n_fail++; close_out; end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {cyc, stb, we, go, rst_n} = '0; adr = 0; dat = 0; val = 0;
    n_fail = 0; n_tests = 0; cnt = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    xfer(`ILD_ADDR_THRESH, 1'b1, 32'h0000_0100);
    // field 2 asks for four samples per period
    xfer(`ILD_ADDR_CFG, 1'b1, 32'h0000_8001);
    xfer(`ILD_ADDR_START, 1'b1, 32'h0);
    put4(14'h3e00, 14'h0200, 14'h0400, 14'h0400);
    // restart lands on the closing sample: sum dropped, nothing latched
    xfer(`ILD_ADDR_START, 1'b1, 32'h0);
    chk("ready on restart", rdy, 1'b0);
    put4(14'h3e00, 14'h0200, 14'h0400, 14'h3c00);
    wait_rdy;
    chk("ready set", rdy, 1'b1);
    rd(`ILD_ADDR_STATUS, 32'h1, "status single");
    rd(`ILD_ADDR_LVL0, 32'h08, "level0");
    rd(`ILD_ADDR_LVL1, 32'h0, "level1");
    rd(`ILD_ADDR_LVL2, 32'h0, "level2");
    repeat (2) @(posedge ref_clk);
    chk("ready cleared", rdy, 1'b0);
    put4(14'h0400, 14'h0400, 14'h0400, 14'h0400);
    repeat (8) @(posedge ref_clk);
    chk("single stopped", rdy, 1'b0);
    xfer(`ILD_ADDR_CFG, 1'b1, 32'h0000_8006);
    xfer(`ILD_ADDR_START, 1'b1, 32'h0);
    chk("stuffed valid", fe_v, 1'b1);
    put4(14'h2400, 14'h1c00, 14'h2400, 14'h1c00);
    wait_rdy;
    rd(`ILD_ADDR_STATUS, 32'h3, "status free");
    rd(`ILD_ADDR_LVL0, 32'h0a, "offset level0");
    rd(`ILD_ADDR_LVL2, 32'h0, "offset level2");
    put4(14'h2400, 14'h1c00, 14'h2400, 14'h1c00);
    wait_rdy;
    chk("free reload", rdy, 1'b1);
    rd(`ILD_ADDR_LVL0, 32'h0a, "reload level0");
    rd(8'h1c, 32'h0, "unmapped");
    rd(`ILD_ADDR_START, 32'h0, "start reads");
    close_out;
  end
endmodule
`default_nettype wire
